// ---- gspd_pkg.sv ----
// Constants, field layouts and the frame summary type for the global
// sector protect decode block.
// Assumes a mode 0 serial link and a single system clock for the core.
package gspd_pkg;

   // ==========================================================
   // Serial opcodes
   localparam logic [7:0] GSPD_OP_WR_STATUS1 = 8'h01;
   localparam logic [7:0] GSPD_OP_RD_STATUS  = 8'h05;
   localparam logic [7:0] GSPD_OP_WR_DISABLE = 8'h04;
   localparam logic [7:0] GSPD_OP_WR_ENABLE  = 8'h06;

   // ==========================================================
   // Status byte one field positions
   localparam int GSPD_BIT_LOCK   = 7;
   localparam int GSPD_BIT_WP     = 4;
   localparam int GSPD_BIT_SWP_HI = 3;
   localparam int GSPD_BIT_SWP_LO = 2;
   localparam int GSPD_BIT_WEL    = 1;
   localparam int GSPD_GLB_HI     = 5;
   localparam int GSPD_GLB_LO     = 2;

   // Global decode patterns of bits five to two
   localparam logic [3:0] GSPD_GLB_PROTECT   = 4'hF;
   localparam logic [3:0] GSPD_GLB_UNPROTECT = 4'h0;

   // Software protection status field
   localparam logic [1:0] GSPD_SWP_NONE = 2'h0;
   localparam logic [1:0] GSPD_SWP_SOME = 2'h1;
   localparam logic [1:0] GSPD_SWP_ALL  = 2'h3;

   // ==========================================================
   // Reset values, sector count and frame byte limit
   localparam logic       GSPD_RST_LOCK = 1'h0;
   localparam logic       GSPD_RST_WEL  = 1'h0;
   localparam logic       GSPD_RST_PROT = 1'h1;
   localparam int         GSPD_NUM_SECTORS = 128;
   localparam logic [1:0] GSPD_BYTES_MAX = 2'h3;

   // ==========================================================
   // Summary of the last frame, kept by the link side
   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] data;
      logic [1:0] nbytes;
      logic       aligned;
   } gspd_frame_s;

endpackage

// ---- gspd_sync.sv ----
// Two flip-flop level synchroniser, one bit lane per width bit.
// Assumes the destination clock and its asynchronous low reset.
`timescale 1ns/100ps
module gspd_sync #(
   parameter int         WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   // Data
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;

   // The first stage feeds only the second stage
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= RST_VAL;
         q      <= RST_VAL;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

// ---- gspd_core.sv ----
// Global protect and unprotect decode of status byte one writes, with
// lock bit control, write enable latch and status read-back.
// Assumes a mode 0 serial host on sck and cs_n, a write-protect pin
// wp_n, and same-clock sector command and suspend inputs.
//
// How it works
// - Bits 5..2 all ones protects every sector
// - Bits 5..2 all zeros unprotects every sector
// - Other patterns only touch the lock bit and the latch
// - Pin low, lock set: only the latch clears
// - Pin high, lock set: only lock and latch update
// - Only bit seven is stored as lock
// - Read-back shows pin and protection status
// - Global protect during suspend aborts, clears latch
// - 0Fh clears lock when pin deasserted
// - F0h sets lock, protection unchanged
// - Single sector commands still work afterwards while the lock bit is clear
// - Status write needs write enable latch set
`timescale 1ns/100ps
module gspd_core
   import gspd_pkg::*;
#(
   parameter int NUM_SECTORS = gspd_pkg::GSPD_NUM_SECTORS,
   parameter int IDX_W       = $clog2(NUM_SECTORS)
) (
   // System clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   rstn,
   // Serial link pins
   input  wire logic                   sck,
   input  wire logic                   cs_n,
   input  wire logic                   si,
   output logic                        so_q,
   output logic                        so_oe_q,
   // Write-protect pin, active low
   input  wire logic                   wp_n,
   // Program or erase suspend, from the array sequencer
   input  wire logic                   suspend_active,
   // Single sector protect and unprotect commands
   input  wire logic                   sect_cmd_valid,
   input  wire logic                   sect_cmd_protect,
   input  wire logic [IDX_W-1:0]       sect_cmd_index,
   // State towards the array and status
   output logic [NUM_SECTORS-1:0]      sector_prot_q,
   output logic                        protection_regs_lock_q,
   output logic                        write_enable_latch_q,
   output logic [7:0]                  status_q
);
   import gspd_pkg::*;

   // ==========================================================
   // Link side: frame capture on the serial clock
   // Frame counters clear while the chip is deselected, so each frame
   // starts from bit zero even if the previous one ended off a byte.
   logic              link_rst_n;
   logic [2:0]        bit_cnt_q;
   logic [6:0]        shift_q;
   logic [1:0]        byte_idx_q;
   logic              started_q;
   logic              rd_en_q;
   logic [7:0]        rx_byte;
   logic              byte_done;
   logic [1:0]        byte_idx_d;
   gspd_frame_s       frame_q;
   logic              frame_tgl_q;

   assign link_rst_n = rstn & ~cs_n;
   assign rx_byte    = {shift_q, si};
   assign byte_done  = (bit_cnt_q == 3'h7);

   always_comb begin
      byte_idx_d = byte_idx_q;
      if (byte_done && byte_idx_q != GSPD_BYTES_MAX) begin
         byte_idx_d = byte_idx_q + 2'h1;
      end
   end

   always_ff @(posedge sck or negedge link_rst_n) begin
      if (!link_rst_n) begin
         bit_cnt_q  <= 3'h0;
         shift_q    <= 7'h00;
         byte_idx_q <= 2'h0;
         started_q  <= 1'b0;
      end else begin
         bit_cnt_q  <= bit_cnt_q + 3'h1;
         shift_q    <= rx_byte[6:0];
         byte_idx_q <= byte_idx_d;
         started_q  <= 1'b1;
      end
   end

   // Summary survives deselection so the core can read it afterwards;
   // it only moves on serial clock edges, which stop with the frame.
   always_ff @(posedge sck or negedge rstn) begin
      if (!rstn) begin
         frame_q     <= '0;
         frame_tgl_q <= 1'b0;
      end else begin
         frame_q.aligned <= byte_done;
         frame_q.nbytes  <= byte_idx_d;
         if (byte_done && byte_idx_q == 2'h0) begin
            frame_q.opcode <= rx_byte;
         end
         if (byte_done && byte_idx_q == 2'h1) begin
            frame_q.data <= rx_byte;
         end
         if (!started_q) begin
            frame_tgl_q <= ~frame_tgl_q;
         end
      end
   end

   // Read of the status opens after the opcode byte
   always_ff @(posedge sck or negedge link_rst_n) begin
      if (!link_rst_n) begin
         rd_en_q <= 1'b0;
      end else if (byte_done && byte_idx_q == 2'h0) begin
         rd_en_q <= (rx_byte == GSPD_OP_RD_STATUS);
      end
   end

   // Status changes in the core at frame ends, on sector commands and
   // on wp_n pin changes, and is sampled here directly.
   always_ff @(negedge sck or negedge link_rst_n) begin
      if (!link_rst_n) begin
         so_q    <= 1'b0;
         so_oe_q <= 1'b0;
      end else begin
         so_q    <= rd_en_q & status_q[~bit_cnt_q];
         so_oe_q <= rd_en_q;
      end
   end

   // ==========================================================
   // Core side: pin synchronisers and frame end detection
   logic              cs_sync;
   logic              wp_sync;
   logic              tgl_sync;
   logic              cs_prev_q;
   logic              done_tgl_q;
   logic              frame_end;

   gspd_sync #(.WIDTH(3), .RST_VAL(3'b101)) u_sync (
      .clk  (sys_clk),
      .rstn (rstn),
      .d    ({cs_n, frame_tgl_q, wp_n}),
      .q    ({cs_sync, tgl_sync, wp_sync})
   );

   // A release with no clock edges in the frame leaves the toggle
   // alone and so never replays the previous command.
   assign frame_end = cs_sync & ~cs_prev_q & (tgl_sync != done_tgl_q);

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cs_prev_q  <= 1'b1;
         done_tgl_q <= 1'b0;
      end else begin
         cs_prev_q <= cs_sync;
         if (frame_end) begin
            done_tgl_q <= tgl_sync;
         end
      end
   end

   // ==========================================================
   // Command decode
   logic              frame_ok;
   logic              op_wren;
   logic              op_wrdi;
   logic              op_wrsr;
   logic              wrsr_go;
   logic              hw_locked;
   logic [3:0]        glb_bits;
   logic              glb_prot;
   logic              glb_unprot;
   logic              glb_abort;
   logic              sect_go;

   assign frame_ok  = frame_end & frame_q.aligned
                      & (frame_q.nbytes != 2'h0);
   assign op_wren   = frame_ok & (frame_q.opcode == GSPD_OP_WR_ENABLE);
   assign op_wrdi   = frame_ok & (frame_q.opcode == GSPD_OP_WR_DISABLE);
   assign op_wrsr   = frame_end & (frame_q.opcode == GSPD_OP_WR_STATUS1)
                      & (frame_q.nbytes != 2'h0);
   assign wrsr_go   = op_wrsr & frame_ok & (frame_q.nbytes != 2'h1)
                      & write_enable_latch_q;
   assign hw_locked = protection_regs_lock_q & ~wp_sync;
   assign glb_bits  = frame_q.data[GSPD_GLB_HI:GSPD_GLB_LO];
   // Globals run only from the unlocked state, in both pin states
   assign glb_prot   = wrsr_go & ~protection_regs_lock_q
                       & (glb_bits == GSPD_GLB_PROTECT);
   assign glb_unprot = wrsr_go & ~protection_regs_lock_q
                       & (glb_bits == GSPD_GLB_UNPROTECT);
   assign glb_abort  = glb_prot & suspend_active;
   assign sect_go    = sect_cmd_valid & write_enable_latch_q
                       & ~protection_regs_lock_q & ~frame_end;

   // ==========================================================
   // Lock bit: only bit seven of the written byte is kept
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         protection_regs_lock_q <= GSPD_RST_LOCK;
      end else if (wrsr_go && !hw_locked && !glb_abort) begin
         protection_regs_lock_q <= frame_q.data[GSPD_BIT_LOCK];
      end
   end
   // Soft lock: the line above still takes the new value while no
   // global runs, which gives the 0Fh and F0h paths.

   // ==========================================================
   // Sector protection bits
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sector_prot_q <= {NUM_SECTORS{GSPD_RST_PROT}};
      end else if (glb_prot && !glb_abort) begin
         sector_prot_q <= {NUM_SECTORS{1'b1}};
      end else if (glb_unprot) begin
         sector_prot_q <= {NUM_SECTORS{1'b0}};
      end else if (sect_go) begin
         sector_prot_q[sect_cmd_index] <= sect_cmd_protect;
      end
      // Any other pattern falls through with no change
   end

   // ==========================================================
   // Write enable latch
   // Any status write attempt, taken or refused, drops the latch so a
   // stray second write needs a fresh enable.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         write_enable_latch_q <= GSPD_RST_WEL;
      end else if (op_wren) begin
         write_enable_latch_q <= 1'b1;
      end else if (op_wrdi || op_wrsr) begin
         write_enable_latch_q <= 1'b0;
      end else if (sect_cmd_valid && write_enable_latch_q
                   && !frame_end) begin
         write_enable_latch_q <= 1'b0;
      end
   end

   // ==========================================================
   // Status byte one image for read-back
   function automatic logic [1:0] swp_code(
      input logic [NUM_SECTORS-1:0] prot
   );
      if (&prot) begin
         swp_code = GSPD_SWP_ALL;
      end else if (|prot) begin
         swp_code = GSPD_SWP_SOME;
      end else begin
         swp_code = GSPD_SWP_NONE;
      end
   endfunction

   // Built from state, never from written bits five to two
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         status_q <= 8'h00;
      end else begin
         status_q <= 8'h00;
         status_q[GSPD_BIT_LOCK] <= protection_regs_lock_q;
         status_q[GSPD_BIT_WP]   <= wp_sync;
         status_q[GSPD_BIT_SWP_HI:GSPD_BIT_SWP_LO] <=
            swp_code(sector_prot_q);
         status_q[GSPD_BIT_WEL]  <= write_enable_latch_q;
      end
   end
   // Suspended sectors are kept unprotected by the host.
   // A global from soft lock takes two writes from the host.
endmodule

// ---- gspd_assertions.sv ----
// Checker for the global protect decode core.
// Bound to gspd_core; sees only its ports.
`timescale 1ns/100ps
module gspd_assertions
   import gspd_pkg::*;
#(
   parameter int NUM_SECTORS = GSPD_NUM_SECTORS
) (
   // Clock and reset
   input wire logic                   sys_clk,
   input wire logic                   rstn,
   // Pins and commands
   input wire logic                   cs_n,
   input wire logic                   wp_n,
   input wire logic                   suspend_active,
   input wire logic                   sect_cmd_valid,
   input wire logic                   so_oe_q,
   // State
   input wire logic [NUM_SECTORS-1:0] sector_prot_q,
   input wire logic                   protection_regs_lock_q,
   input wire logic                   write_enable_latch_q,
   input wire logic [7:0]             status_q
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // ======
   // Protection bits
   property p_whole;
      $changed(sector_prot_q) && !$past(sect_cmd_valid)
         |-> sector_prot_q == '1 || sector_prot_q == '0;
   endproperty
   a_whole: assert property (p_whole)
      else $error("partial change outside a sector command");
   property p_soft_lock;
      protection_regs_lock_q |=> $stable(sector_prot_q);
   endproperty
   a_soft_lock: assert property (p_soft_lock)
      else $error("protection changed while locked");
   property p_suspend;
      suspend_active [*4] ##0 !sect_cmd_valid
         |=> !(sector_prot_q == '1 && $changed(sector_prot_q));
   endproperty
   a_suspend: assert property (p_suspend)
      else $error("global protect done during suspend");
   property p_need_wel;
      $changed(sector_prot_q)
         |-> $past(write_enable_latch_q) && !write_enable_latch_q;
   endproperty
   a_need_wel: assert property (p_need_wel)
      else $error("protection changed without write enable");
   // ======
   // Lock bit, status image and output enable
   property p_hard_lock;
      !wp_n [*6] ##0 protection_regs_lock_q |=> protection_regs_lock_q;
   endproperty
   a_hard_lock: assert property (p_hard_lock)
      else $error("lock cleared with pin low");
   property p_lock_wel;
      $changed(protection_regs_lock_q)
         |-> $fell(write_enable_latch_q) && $past(cs_n, 2);
   endproperty
   a_lock_wel: assert property (p_lock_wel)
      else $error("lock moved outside a status write");
   property p_status;
      $past(rstn) |-> status_q == {$past(protection_regs_lock_q), 2'h0,
         $past(wp_n, 3), (&$past(sector_prot_q)) ? GSPD_SWP_ALL :
         (|$past(sector_prot_q)) ? GSPD_SWP_SOME : GSPD_SWP_NONE,
         $past(write_enable_latch_q), 1'h0};
   endproperty
   a_status: assert property (p_status)
      else $error("status image wrong");
   property p_so_oe;
      so_oe_q |-> !cs_n;
   endproperty
   a_so_oe: assert property (p_so_oe)
      else $error("output driven while deselected");
endmodule
bind gspd_core gspd_assertions #(.NUM_SECTORS(NUM_SECTORS)) u_chk (
   .sys_clk                (sys_clk),
   .rstn                   (rstn),
   .cs_n                   (cs_n),
   .wp_n                   (wp_n),
   .suspend_active         (suspend_active),
   .sect_cmd_valid         (sect_cmd_valid),
   .so_oe_q                (so_oe_q),
   .sector_prot_q          (sector_prot_q),
   .protection_regs_lock_q (protection_regs_lock_q),
   .write_enable_latch_q   (write_enable_latch_q),
   .status_q               (status_q)
);

// ---- gspd_host.sv ----
// Host model of the serial link, mode 0, link clock only inside frames.
// Assumes the core samples si on sck rise and drives so on sck fall.
`timescale 1ns/100ps
module gspd_host (
   // Link outputs
   output logic     sck,
   output logic     cs_n,
   output logic     si,
   // Link inputs
   input wire logic so_q,
   input wire logic so_oe_q
);
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end
   // ======
   // One frame of n bits, MSB first; reads so from the ninth bit on
   task automatic xfer(input logic [15:0] d, input int n,
                       output logic [7:0] rd);
      int i;
      rd = 8'h00;
      #37 cs_n = 1'b0;
      for (i = 0; i < n; i++) begin
         si = d[15-i];
         #80 sck = 1'b1;
         // Sample at the rise, half a period after the device launched it
         if (i >= 8 && so_oe_q) rd = {rd[6:0], so_q};
         #80 sck = 1'b0;
      end
      // No pull on si, so a released line must not keep its value
      si = ~si;
      #80 cs_n = 1'b1;
      #400;
   endtask
endmodule

// ---- global_sector_protect_decode_tb.sv ----
// Self-checking bench for gspd_core with the host model on the link.
// Assumes the core's default of 128 sectors.
`timescale 1ns/100ps
module global_sector_protect_decode_tb;
   import gspd_pkg::*;
   logic         sys_clk, rstn, sck, cs_n, si, so_q, so_oe_q, wp_n;
   logic         suspend_active, sect_cmd_valid, sect_cmd_protect;
   logic [6:0]   sect_cmd_index;
   logic [127:0] sector_prot_q, m_prot;
   logic         protection_regs_lock_q, write_enable_latch_q;
   logic         m_lock, m_wel;
   logic [7:0]   status_q, rd, d;
   logic [7:0]   corner [8] = '{8'h00, 8'h7F, 8'hF0, 8'hFF,
                                8'h0F, 8'h04, 8'h38, 8'hFF};
   int           failures, n_compared, cycles, k;
   gspd_core dut (
      .sys_clk                (sys_clk),
      .rstn                   (rstn),
      .sck                    (sck),
      .cs_n                   (cs_n),
      .si                     (si),
      .so_q                   (so_q),
      .so_oe_q                (so_oe_q),
      .wp_n                   (wp_n),
      .suspend_active         (suspend_active),
      .sect_cmd_valid         (sect_cmd_valid),
      .sect_cmd_protect       (sect_cmd_protect),
      .sect_cmd_index         (sect_cmd_index),
      .sector_prot_q          (sector_prot_q),
      .protection_regs_lock_q (protection_regs_lock_q),
      .write_enable_latch_q   (write_enable_latch_q),
      .status_q               (status_q)
   );
   gspd_host h (
      .sck     (sck),
      .cs_n    (cs_n),
      .si      (si),
      .so_q    (so_q),
      .so_oe_q (so_oe_q)
   );
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 60000) begin
         failures++;
         summarize();
      end
   end
   // ======
   // Expectations
   function automatic logic [7:0] exp_status();
      logic [1:0] swp;
      swp = &m_prot ? GSPD_SWP_ALL : |m_prot ? GSPD_SWP_SOME : GSPD_SWP_NONE;
      return {m_lock, 2'h0, wp_n, swp, m_wel, 1'h0};
   endfunction
   function automatic void model_wrsr(input logic [7:0] v);
      logic g, a;
      g = m_wel && !m_lock;
      a = g && suspend_active && v[5:2] == GSPD_GLB_PROTECT;
      if (g && !a && v[5:2] == GSPD_GLB_PROTECT) m_prot = '1;
      if (g && v[5:2] == GSPD_GLB_UNPROTECT) m_prot = '0;
      if (m_wel && !a && (wp_n || !m_lock)) m_lock = v[7];
      m_wel = 1'b0;
   endfunction
   // ======
   // Compares and drivers
   task automatic chk_prot(input logic [127:0] exp);
      n_compared++;
      if (sector_prot_q !== exp) begin
         failures++;
         $display("Error %0t prot %h exp %h", $time, sector_prot_q, exp);
      end
   endtask
   task automatic chk_byte(input logic [7:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("Error %0t status %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wren();
      h.xfer({GSPD_OP_WR_ENABLE, 8'h00}, 8, rd);
      m_wel = 1'b1;
   endtask
   task automatic sect(input logic p, input logic [6:0] i);
      @(posedge sys_clk);
      sect_cmd_valid <= 1'b1;
      sect_cmd_protect <= p;
      sect_cmd_index <= i;
      @(posedge sys_clk);
      sect_cmd_valid <= 1'b0;
      if (m_wel && !m_lock) m_prot[i] = p;
      m_wel = 1'b0;
   endtask
   task automatic summarize();
      $display("Compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ======
   // Main sequence: corner writes first, then random ones
   initial begin
      rstn = 1'b0;
      wp_n = 1'b1;
      suspend_active = 1'b0;
      sect_cmd_valid = 1'b0;
      sect_cmd_protect = 1'b0;
      sect_cmd_index = 7'h00;
      m_prot = '1;
      m_lock = 1'b0;
      m_wel = 1'b0;
      void'($urandom(14100));
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (5) @(posedge sys_clk);
      chk_byte(status_q, exp_status());
      for (k = 0; k < 48; k++) begin
         d = (k < 8) ? corner[k] : 8'($urandom);
         @(posedge sys_clk);
         wp_n <= (k < 8) || ($urandom % 3 != 0);
         suspend_active <= (k == 1) ||
            (k >= 8 && $urandom % 4 == 0 && !(&m_prot));
         @(posedge sys_clk);
         if (k % 7 != 5) wren();
         // Write disable after an enable leaves the status write refused
         if (k == 13) begin
            h.xfer({GSPD_OP_WR_DISABLE, 8'h00}, 8, rd);
            m_wel = 1'b0;
         end
         h.xfer({GSPD_OP_WR_STATUS1, d}, (k == 20) ? 12 : 16, rd);
         if (k == 20) m_wel = 1'b0;
         else model_wrsr(d);
         chk_prot(m_prot);
         chk_byte(status_q, exp_status());
         if (!m_lock) begin
            wren();
            sect(1'($urandom), 7'($urandom));
            repeat (3) @(posedge sys_clk);
            chk_prot(m_prot);
         end
         h.xfer({GSPD_OP_RD_STATUS, 8'h00}, 16, rd);
         chk_byte(rd, exp_status());
      end
      summarize();
   end
endmodule
